// *** core/ulsi_defs.vh ***
`ifndef ULSI_DEFS_VH
`define ULSI_DEFS_VH

// Register offsets
`define ULSI_ADDR_RX_HOLD      8'h00
`define ULSI_ADDR_LS_IRQ_EN    8'h03
`define ULSI_ADDR_LINE_STATUS  8'h04
`define ULSI_ADDR_SC_IRQ_EN    8'h05

// Reset values
`define ULSI_LS_IRQ_EN_RST     6'h00
`define ULSI_SC_IRQ_EN_RST     6'h00

// Line status bit positions
`define ULSI_LS_CTS            7
`define ULSI_LS_NOISE          5
`define ULSI_LS_BREAK          4
`define ULSI_LS_FRAME          3
`define ULSI_LS_PARITY         2
`define ULSI_LS_OVERRUN        1
`define ULSI_LS_TIMEOUT        0

// Special-character flag positions
`define ULSI_SC_ADDR_CHAR      5
`define ULSI_SC_BREAK          4
`define ULSI_SC_STOP_TWO       3
`define ULSI_SC_STOP_ONE       2
`define ULSI_SC_RESUME_TWO     1
`define ULSI_SC_RESUME_ONE     0

// Receive queue geometry
`define ULSI_Q_DEPTH           128
`define ULSI_Q_AW              7
`define ULSI_Q_CW              8
`define ULSI_Q_FULL            8'h80

// Stored per-entry flag positions above the 8 data bits
`define ULSI_E_PARITY          8
`define ULSI_E_FRAME           9
`define ULSI_E_BREAK           10
`define ULSI_E_NOISE           11
`define ULSI_E_W               12

// Timeout: one period unit in clock cycles
`define ULSI_TO_UNIT_CYCLES    24'h000010
`define ULSI_TO_CW             24

`endif

// *** core/ulsi_line_status.v ***
`timescale 1ns/1ps
`include "ulsi_defs.vh"

module ulsi_line_status
(
  input  wire       core_clk_i,            // 50 MHz clock
  input  wire       rst_n_i,               // Async reset, active low
  input  wire [7:0] reg_addr_i,            // Register address
  input  wire       reg_wr_i,              // Write strobe
  input  wire       reg_rd_i,              // Read strobe
  input  wire [7:0] reg_wdata_i,           // Write data
  output reg  [7:0] reg_rdata_o,           // Read data, one cycle after strobe
  input  wire       rx_valid_i,            // Received character pulse
  input  wire [7:0] rx_data_i,             // Received data bits
  input  wire       rx_noise_i,            // Noise seen during character
  input  wire       rx_break_i,            // Character is a line break
  input  wire       rx_frame_err_i,        // Stop bits wrong
  input  wire       rx_parity_bit_i,       // Received parity or ninth bit
  input  wire       parity_en_i,           // Parity checking on
  input  wire       parity_even_i,         // Even parity when high
  input  wire       nine_bit_mode_i,       // Multidrop nine-bit mode
  input  wire       clear_to_send_level_i, // Clear-to-send input level
  input  wire [7:0] receive_timeout_period_i, // Timeout period, zero disables
  input  wire [5:0] special_char_flags_i,  // Special-character event flags
  input  wire       summary_rd_i,          // Interrupt summary being read
  output reg        line_error_summary_o,  // Line-error summary bit
  output reg        special_char_summary_o,// Special-character summary bit
  output reg  [7:0] rx_queue_level_o       // Characters held in queue
);

  reg                    rst_meta;
  reg                    rst_sync;
  reg [`ULSI_E_W-1:0]    queue [0:`ULSI_Q_DEPTH-1];
  reg [`ULSI_Q_AW-1:0]   wr_ptr;
  reg [`ULSI_Q_AW-1:0]   rd_ptr;
  reg [`ULSI_Q_CW-1:0]   count;
  reg [5:0]              ls_irq_en;
  reg [5:0]              sc_irq_en;
  reg [3:0]              char_flags;
  reg                    overrun_flag;
  reg                    stale_data_flag;
  reg [`ULSI_TO_CW-1:0]  to_count;
  reg [`ULSI_TO_CW-1:0]  to_limit;
  reg                    parity_or_ninth;
  reg [`ULSI_E_W-1:0]    head;
  reg [7:0]              line_status;
  reg [7:0]              next_rdata;
  wire                   q_full;
  wire                   q_empty;
  wire                   pop;
  wire                   push;
  wire                   overrun_set;
  wire                   overrun_clr;
  wire                   line_set;
  wire                   special_set;

  wire                   at_hold;
  wire                   at_ls_en;
  wire                   at_status;
  wire                   at_sc_en;
  wire                   hold_rd;
  wire                   status_rd;
  wire                   ls_en_wr;
  wire                   sc_en_wr;
  wire                   expected_parity;
  wire [`ULSI_E_W-1:0]   entry;
  wire                   to_off;
  wire                   to_expired;
  wire [5:0]             line_routed;
  wire [5:0]             special_routed;

  // Reset release through two flops
  // Entry stays asynchronous, so reset works without a running clock
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Address decode shared by strobes
  assign at_hold   = (reg_addr_i == `ULSI_ADDR_RX_HOLD);
  assign at_ls_en  = (reg_addr_i == `ULSI_ADDR_LS_IRQ_EN);
  assign at_status = (reg_addr_i == `ULSI_ADDR_LINE_STATUS);
  assign at_sc_en  = (reg_addr_i == `ULSI_ADDR_SC_IRQ_EN);
  assign hold_rd   = reg_rd_i && at_hold;
  assign status_rd = reg_rd_i && at_status;
  assign ls_en_wr  = reg_wr_i && at_ls_en;
  assign sc_en_wr  = reg_wr_i && at_sc_en;

  // Full is 128, one past the pointer range, so count is one bit wider
  assign q_full  = (count == `ULSI_Q_FULL);
  assign q_empty = (count == 8'h00);
  assign pop     = hold_rd && !q_empty;
  // A pop in the same cycle frees the slot, so the character fits
  assign push    = rx_valid_i && (!q_full || pop);
  assign overrun_set = rx_valid_i && q_full && !pop;
  assign overrun_clr = status_rd || (count < `ULSI_Q_FULL);

  always @*
  begin
    parity_or_ninth = 1'b0;
    if (nine_bit_mode_i)
      parity_or_ninth = rx_parity_bit_i;
    else if (parity_en_i)
      parity_or_ninth = rx_parity_bit_i != expected_parity;
  end

  // Even parity: the parity bit equals the XOR of the data bits
  assign expected_parity = parity_even_i ? ^rx_data_i : ~^rx_data_i;

  // Data and flags travel together so status matches the popped character
  always @(posedge core_clk_i)
  begin
    if (push)
      queue[wr_ptr] <= entry;
  end

  // A break is stored as zero whatever the data lines show
  assign entry = {rx_noise_i, rx_break_i, rx_frame_err_i, parity_or_ninth,
                  rx_break_i ? 8'h00 : rx_data_i};

  // Head is read combinationally; the pop edge captures it
  always @*
  begin
    head = queue[rd_ptr];
  end

  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      wr_ptr <= {`ULSI_Q_AW{1'b0}};
    else if (push)
      wr_ptr <= wr_ptr + 7'h01;
  end

  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      rd_ptr <= {`ULSI_Q_AW{1'b0}};
    else if (pop)
      rd_ptr <= rd_ptr + 7'h01;
  end

  // Push and pop in one cycle leave the count alone
  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      count <= {`ULSI_Q_CW{1'b0}};
    else if (push && !pop)
      count <= count + 8'h01;
    else if (pop && !push)
      count <= count - 8'h01;
  end

  // Flags change only on a pop; reading status leaves them alone
  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      char_flags <= 4'h0;
    else if (pop)
    begin
      char_flags[3] <= head[`ULSI_E_NOISE];
      char_flags[2] <= head[`ULSI_E_BREAK];
      char_flags[1] <= head[`ULSI_E_FRAME];
      char_flags[0] <= head[`ULSI_E_PARITY];
    end
  end

  // Set wins over clear so a late overrun is never lost
  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      overrun_flag <= 1'b0;
    else if (overrun_set)
      overrun_flag <= 1'b1;
    else if (overrun_clr)
      overrun_flag <= 1'b0;
  end

  // Period counts in units of 16 clocks; the product fits 24 bits
  always @*
  begin
    to_limit = {16'h0000, receive_timeout_period_i} * `ULSI_TO_UNIT_CYCLES;
  end

  assign to_off     = (receive_timeout_period_i == 8'h00);
  assign to_expired = (to_count >= to_limit - 24'h000001);

  // Counter only runs while something waits in the queue
  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      to_count <= {`ULSI_TO_CW{1'b0}};
    else if (push || pop)
      to_count <= {`ULSI_TO_CW{1'b0}};
    else if (to_off)
      to_count <= {`ULSI_TO_CW{1'b0}};
    else if (!q_empty && !stale_data_flag && !to_expired)
      to_count <= to_count + 24'h000001;
  end

  // Queue traffic wins over expiry, so a fresh character is never stale
  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      stale_data_flag <= 1'b0;
    else if (push || pop)
      stale_data_flag <= 1'b0;
    else if (to_off)
      stale_data_flag <= 1'b0;
    else if (!q_empty && to_expired)
      stale_data_flag <= 1'b1;
  end

  // Enables keep bits 5:0 only; 7:6 read back as zero
  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      ls_irq_en <= `ULSI_LS_IRQ_EN_RST;
    else if (ls_en_wr)
      ls_irq_en <= reg_wdata_i[5:0];
  end

  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      sc_irq_en <= `ULSI_SC_IRQ_EN_RST;
    else if (sc_en_wr)
      sc_irq_en <= reg_wdata_i[5:0];
  end

  always @*
  begin
    line_status                   = 8'h00;
    line_status[`ULSI_LS_CTS]     = clear_to_send_level_i;
    line_status[`ULSI_LS_NOISE]   = char_flags[3];
    line_status[`ULSI_LS_BREAK]   = char_flags[2];
    line_status[`ULSI_LS_FRAME]   = char_flags[1];
    line_status[`ULSI_LS_PARITY]  = char_flags[0];
    line_status[`ULSI_LS_OVERRUN] = overrun_flag;
    line_status[`ULSI_LS_TIMEOUT] = stale_data_flag;
  end

  // One gate per flag; bits 7:6 have no enable, so CTS never sets the summary
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_route
      assign line_routed[gi]    = line_status[gi] & ls_irq_en[gi];
      assign special_routed[gi] = special_char_flags_i[gi] & sc_irq_en[gi];
    end
  endgenerate

  assign line_set    = |line_routed;
  assign special_set = |special_routed;

  // Level set wins over read clear: a source still high re-arms the bit
  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      line_error_summary_o <= 1'b0;
    else if (line_set)
      line_error_summary_o <= 1'b1;
    else if (summary_rd_i)
      line_error_summary_o <= 1'b0;
  end

  // Special summary follows the same set-over-clear order
  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      special_char_summary_o <= 1'b0;
    else if (special_set)
      special_char_summary_o <= 1'b1;
    else if (summary_rd_i)
      special_char_summary_o <= 1'b0;
  end

  // Unmapped addresses and an empty queue read zero
  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `ULSI_ADDR_RX_HOLD:
        next_rdata = q_empty ? 8'h00 : head[7:0];
      `ULSI_ADDR_LS_IRQ_EN:
        next_rdata = {2'b00, ls_irq_en};
      `ULSI_ADDR_LINE_STATUS:
        next_rdata = line_status;
      `ULSI_ADDR_SC_IRQ_EN:
        next_rdata = {2'b00, sc_irq_en};
      default:
        next_rdata = 8'h00;
    endcase
  end

  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
  end

  // Level lags the count by one cycle so the output comes from a flop
  always @(posedge core_clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
      rx_queue_level_o <= 8'h00;
    else
      rx_queue_level_o <= count;
  end

endmodule

// *** verification/tb_ulsi_line_status.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end

module tb_ulsi_line_status;
  reg        clk, rst_n = 0, vld = 0, nz = 0, brk = 0, fe = 0, pb = 0, nine = 0, cts = 0, srd = 0;
  reg  [7:0] rxd = 0, per = 0, d, s;
  reg  [5:0] scf = 0;
  wire [7:0] addr, wdata, rdata, lvl;
  wire       wr, rd, les, scs;
  integer    failures = 0, num_checks = 0, i;
  ulsi_host_model u_host (.clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
  ulsi_line_status u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .rx_valid_i(vld), .rx_data_i(rxd), .rx_noise_i(nz), .rx_break_i(brk),
    .rx_frame_err_i(fe), .rx_parity_bit_i(pb), .parity_en_i(1'b1), .parity_even_i(1'b1),
    .nine_bit_mode_i(nine), .clear_to_send_level_i(cts), .receive_timeout_period_i(per),
    .special_char_flags_i(scf), .summary_rd_i(srd), .line_error_summary_o(les),
    .special_char_summary_o(scs), .rx_queue_level_o(lvl));
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task push(input [7:0] v, input [2:0] f, input p);
  begin
    @(negedge clk);
    {vld, rxd, nz, brk, fe, pb} = {1'b1, v, f, p};
    @(negedge clk);
    vld = 0;
  end
  endtask
  task t_regs;
  begin
    u_host.rd(8'h03, d);
    `CHK(d, 8'h00)
    u_host.rd(8'h05, d);
    `CHK(d, 8'h00)
    u_host.wr(8'h03, 8'hFF);
    u_host.wr(8'h05, 8'hFF);
    u_host.wr(8'h04, 8'hFF);
    u_host.rd(8'h03, d);
    `CHK(d, 8'h3F)
    u_host.rd(8'h05, d);
    `CHK(d, 8'h3F)
    u_host.rd(8'h07, d);
    `CHK(d, 8'h00)
    u_host.rd(8'h04, d);
    `CHK(d, 8'h00)
    u_host.wr(8'h03, 8'h00);
    u_host.wr(8'h05, 8'h00);
    for (i = 1; i >= 0; i--)
    begin
      cts = i[0];
      u_host.rd(8'h04, s);
      `CHK(s[7], i[0])
    end
    $display("t_regs done");
  end
  endtask
  task t_flags;
  begin
    for (i = 0; i < 5; i++)
      push(i == 1 ? 8'h00 : 8'h50 + i, i < 3 ? 3'b100 >> i : 3'b000,
           ^(i == 1 ? 8'h00 : 8'h50 + i) ^ (i == 3));
    for (i = 0; i < 5; i++)
    begin
      u_host.pop(d, s);
      `CHK(d, i == 1 ? 8'h00 : 8'h50 + i)
      `CHK(s[5:2], 4'b1000 >> i)
      u_host.rd(8'h04, s);
      `CHK(s[5:2], 4'b1000 >> i)
    end
    nine = 1;
    push(8'h11, 3'b000, 1'b1);
    push(8'h13, 3'b000, 1'b0);
    u_host.pop(d, s);
    `CHK(s[2], 1'b1)
    u_host.pop(d, s);
    `CHK(s[2], 1'b0)
    nine = 0;
    $display("t_flags done");
  end
  endtask
  task t_ovr;
  begin
    for (i = 0; i < 129; i++)
      push(i[7:0], 3'b000, ^i[7:0]);
    `CHK(lvl, 8'h80)
    u_host.rd(8'h04, s);
    `CHK(s[1], 1'b1)
    u_host.rd(8'h04, s);
    `CHK(s[1], 1'b0)
    push(8'hEE, 3'b000, 1'b0);
    u_host.rd(8'h00, d);
    `CHK(d, 8'h00)
    u_host.rd(8'h04, s);
    `CHK(s[1], 1'b0)
    for (i = 1; i < 128; i++)
    begin
      u_host.rd(8'h00, d);
      `CHK(d, i[7:0])
    end
    u_host.rd(8'h00, d);
    `CHK(d, 8'h00)
    $display("t_ovr done");
  end
  endtask
  task t_tmo;
  begin
    per = 8'h01;
    push(8'h33, 3'b000, 1'b0);
    repeat (8) @(negedge clk);
    u_host.rd(8'h04, s);
    `CHK(s[0], 1'b0)
    repeat (20) @(negedge clk);
    u_host.rd(8'h04, s);
    `CHK(s[0], 1'b1)
    `CHK(les, 1'b0)
    u_host.wr(8'h03, 8'h01);
    repeat (2) @(negedge clk);
    `CHK(les, 1'b1)
    u_host.pop(d, s);
    `CHK(s[0], 1'b0)
    srd = 1;
    @(negedge clk);
    srd = 0;
    `CHK(les, 1'b0)
    per = 8'h00;
    push(8'h44, 3'b000, 1'b0);
    repeat (40) @(negedge clk);
    u_host.pop(d, s);
    `CHK(s[0], 1'b0)
    $display("t_tmo done");
  end
  endtask
  task t_spcl;
  begin
    for (i = 0; i < 6; i++)
    begin
      u_host.wr(8'h05, 8'h01 << i);
      {scf, srd} = {~(6'h01 << i), 1'b1};
      @(negedge clk);
      srd = 0;
      `CHK(scs, 1'b0)
      scf = 6'h01 << i;
      repeat (2) @(negedge clk);
      `CHK(scs, 1'b1)
      {scf, srd} = 7'h01;
      @(negedge clk);
      srd = 0;
      `CHK(scs, 1'b0)
    end
    $display("t_spcl done");
  end
  endtask
  task results;
  begin
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    t_regs;
    t_flags;
    t_ovr;
    t_tmo;
    t_spcl;
    results;
  end
  initial
  begin
    #1000000;
    failures++;
    results;
  end
endmodule

// *** verification/ulsi_host_model.sv ***
`timescale 1ns/1ps

module ulsi_host_model
(
  input  wire [7:0] reg_rdata_i, // Read data
  input  wire       clk_i,       // Clock
  output reg  [7:0] reg_addr_o,  // Address
  output reg        reg_wr_o,    // Write strobe
  output reg        reg_rd_o,    // Read strobe
  output reg  [7:0] reg_wdata_o  // Write data
);
  initial
  begin
    {reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = 18'h00000;
  end
  // Released lines flip so stale values cannot pass
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge clk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
    @(negedge clk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(negedge clk_i);
    {reg_addr_o, reg_rd_o} = {a, 1'b1};
    @(negedge clk_i);
    d = reg_rdata_i;
    {reg_addr_o, reg_rd_o} = {~a, 1'b0};
  end
  endtask
  // Flags only last until the next pop
  task pop(output [7:0] d, output [7:0] s);
  begin
    rd(8'h00, d);
    rd(8'h04, s);
  end
  endtask
endmodule

// *** verification/ulsi_line_status_assertions.sv ***
`timescale 1ns/1ps

module ulsi_line_status_chk
(
  input wire       core_clk_i,
  input wire       rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire       rx_valid_i,
  input wire       clear_to_send_level_i,
  input wire [7:0] receive_timeout_period_i,
  input wire [5:0] special_char_flags_i,
  input wire       summary_rd_i,
  input wire       special_char_summary_o,
  input wire [7:0] rx_queue_level_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ls_rd = reg_rd_i && reg_addr_i == 8'h04;
  wire en_rd = reg_rd_i && (reg_addr_i == 8'h03 || reg_addr_i == 8'h05);
  cts_mirror_a: assert property (ls_rd |=> reg_rdata_o[7] == $past(clear_to_send_level_i))
    else $error("cts bit wrong");
  en_unused_a: assert property (en_rd |=> reg_rdata_o[7:6] == 2'b00)
    else $error("enable bits 7:6 set");
  tmo_off_a: assert property (ls_rd && receive_timeout_period_i == 8'h00 &&
    $past(receive_timeout_period_i) == 8'h00 |=> !reg_rdata_o[0]) else $error("timeout at 0");
  sc_set_a: assert property ($rose(special_char_summary_o)
    |-> $past(special_char_flags_i) != 6'h00) else $error("summary without source");
  sc_clear_a: assert property (summary_rd_i && special_char_flags_i == 6'h00
    |=> !special_char_summary_o) else $error("summary not cleared");
  lvl_max_a: assert property (rx_queue_level_o <= 8'h80)
    else $error("queue above 128");
  hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  ovr_rd_a: assert property ((ls_rd && !rx_valid_i) ##1 !rx_valid_i ##1 ls_rd
    |=> !reg_rdata_o[1]) else $error("overrun not cleared");
endmodule

bind ulsi_line_status ulsi_line_status_chk u_chk (.*);
